// File: tpc_regs.svh
// Register offsets, field positions, reset values and counts of the timer block
`ifndef TPC_REGS_SVH
`define TPC_REGS_SVH

// Byte offsets on the APB port
`define TPC_OFS_SETUP 12'h000
`define TPC_OFS_DIVISOR 12'h004
`define TPC_OFS_END 12'h008
`define TPC_OFS_COUNT 12'h00C
`define TPC_OFS_STATUS 12'h010
`define TPC_OFS_CONTROL 12'h014
`define TPC_OFS_DMA_LEFT 12'h018
`define TPC_OFS_DMA_LOW 12'h01C
`define TPC_OFS_DMA_HIGH 12'h020
`define TPC_OFS_QUEUE_LOW 12'h024
`define TPC_OFS_QUEUE_HIGH 12'h028

// event_status fields
`define TPC_ST_DMA_DONE 7
`define TPC_ST_OVERFLOW 6
`define TPC_ST_REQUEST 5
`define TPC_ST_EVENT 4

// mode_control fields
`define TPC_CT_CAP_MODE 0
`define TPC_CT_CLEAR_ALL 1
`define TPC_CT_COUNT_EN 2
`define TPC_CT_OUT_EN 3
`define TPC_CT_DMA_EN 4
`define TPC_CT_POLARITY 5
`define TPC_CT_EDGE_LO 6
`define TPC_CT_EDGE_HI 7

// Setup fields
`define TPC_SU_IE_END 7
`define TPC_SU_IE_OV 6
`define TPC_SU_IE_REQ 5
`define TPC_SU_IE_ACT 4
`define TPC_SU_CAP_LEVEL 2

// Reset values
`define TPC_CONTROL_RESET 8'h02
`define TPC_DIVISOR_RESET 12'h020
`define TPC_DMA_LEFT_RESET 8'h00

// Queue depth and request levels
`define TPC_QUEUE_DEPTH 4'h8
`define TPC_REQ_CAPTURE 4'h4
`define TPC_REQ_PWM 4'h3

// Minimum accepted pulse, in divided clocks
`define TPC_WIDTH_SLOW 3'h4
`define TPC_WIDTH_FAST 3'h1

// Word repeats, stored as count minus one
`define TPC_REP_1 4'h0
`define TPC_REP_4 4'h3
`define TPC_REP_8 4'h7
`define TPC_REP_16 4'hF

// Edge select codes
`define TPC_EDGE_OFF 2'h0
`define TPC_EDGE_ANY 2'h1
`define TPC_EDGE_FALL 2'h2
`define TPC_EDGE_RISE 2'h3

`endif

// File: tpc_pkg.sv
// Types shared by the timer block
package tpc_pkg;
  typedef enum logic [2:0] {
    TPC_DMA_IDLE = 3'b001,
    TPC_DMA_BUSY = 3'b010,
    TPC_DMA_HOLD = 3'b100
  } tpc_dma_state_type;

  typedef struct packed {
    logic req;
    logic we;
    logic [11:0] addr;
    logic [15:0] wdata;
  } tpc_dma_req_type;
endpackage

// File: tpc_queue_mem.sv
// Eight-word storage of the sample queue, read data registered
`timescale 1ns/1ns
`default_nettype none
module tpc_queue_mem (
  input wire logic pclk,
  input wire logic we,
  input wire logic [2:0] waddr,
  input wire logic [15:0] wdata,
  input wire logic [2:0] raddr,
  output logic [15:0] rdata
);
  logic [15:0] mem [0:7];

  // Write port
  always_ff @(posedge pclk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  // Bypass so a word written into an empty queue is seen at once
  always_ff @(posedge pclk) begin
    if (we && (waddr == raddr)) begin
      rdata <= wdata;
    end else begin
      rdata <= mem[raddr];
    end
  end
endmodule // tpc_queue_mem
`default_nettype wire

// File: tpc_input_filter.sv
// Capture pin synchroniser and minimum pulse width filter
`timescale 1ns/1ns
`default_nettype none
`include "tpc_regs.svh"
module tpc_input_filter (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic pin,
  input wire logic tick,
  input wire logic min_one,
  output logic level
);
  logic sync_a;
  logic sync_b;
  logic [2:0] stable;
  logic [2:0] need;

  // Two flops before anything looks at the pin
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync_a <= 1'b1;
      sync_b <= 1'b1;
    end else begin
      sync_a <= pin;
      sync_b <= sync_a;
    end
  end

  assign need = min_one ? `TPC_WIDTH_FAST : `TPC_WIDTH_SLOW;

  // New level accepted only after holding for the needed divided clocks
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stable <= 3'h0;
      level <= 1'b1;
    end else if (sync_b == level) begin
      stable <= 3'h0;
    end else if (tick) begin
      if ((stable + 3'h1) >= need) begin
        level <= sync_b;
        stable <= 3'h0;
      end else begin
        stable <= stable + 3'h1;
      end
    end
  end
endmodule // tpc_input_filter
`default_nettype wire

// File: tpc_timer_top.sv
// PWM / capture timer with sample queue, DMA channel and APB registers
`timescale 1ns/1ns
`default_nettype none
`include "tpc_regs.svh"
module tpc_timer_top
  import tpc_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic capture_pin,
  output logic pwm_out,
  output logic pwm_oe,
  output tpc_dma_req_type dma_req,
  input wire logic dma_ack,
  input wire logic [15:0] dma_rdata,
  output logic irq
);
  ////////////////////////////////////////////////////////////////////////////
  // Declarations
  logic [3:0] setup_ie;
  logic [7:0] ctrl;
  logic [11:0] divisor;
  logic [15:0] end_value;
  logic [15:0] count;
  logic [11:0] prescale;
  logic [7:0] dma_words_left;
  logic [10:0] dma_word_ptr;
  logic [7:0] queue_hold;
  logic dma_done_flag;
  logic queue_overflow_flag;
  logic queue_request_flag;
  logic event_flag;
  logic [2:0] wr_ptr;
  logic [2:0] rd_ptr;
  logic [2:0] next_rd_ptr;
  logic [3:0] queue_fill_level;
  logic [15:0] head;
  logic [15:0] pwm_word;
  logic [3:0] rep_left;
  logic [3:0] rep_reload;
  logic cap_level;
  logic prev_level;
  logic first_word;
  logic [15:0] dma_buf;
  tpc_dma_state_type dma_state;
  logic [31:0] read_mux;
  logic mapped;
  logic acc;
  logic wr_fire;
  logic rd_fire;
  logic tick;
  logic [11:0] div_m1;
  logic [15:0] end_m1;
  logic pwm_wrap;
  logic pwm_pop;
  logic rise;
  logic fall;
  logic valid_edge;
  logic cap_en;
  logic timeout;
  logic cap_event;
  logic cap_push;
  logic [15:0] cap_word;
  logic sw_push;
  logic sw_pop;
  logic dma_pop;
  logic dma_fetch;
  logic dma_push;
  logic dma_finish;
  logic dma_run;
  logic do_pop;
  logic do_write;
  logic [15:0] push_data;
  logic queue_empty;
  logic queue_full;
  logic overflow_evt;
  logic act_evt;
  logic end_evt;
  logic queue_access;
  logic [7:0] stat_clr;
  logic capture_mode_select;
  logic clear_all_bit;
  logic count_enable_bit;
  logic output_enable_bit;
  logic dma_enable_bit;
  logic pwm_polarity;
  logic [1:0] edge_select;
  logic action_irq_enable;

  assign capture_mode_select = ctrl[`TPC_CT_CAP_MODE];
  assign clear_all_bit = ctrl[`TPC_CT_CLEAR_ALL];
  assign count_enable_bit = ctrl[`TPC_CT_COUNT_EN];
  assign output_enable_bit = ctrl[`TPC_CT_OUT_EN];
  assign dma_enable_bit = ctrl[`TPC_CT_DMA_EN];
  assign pwm_polarity = ctrl[`TPC_CT_POLARITY];
  assign edge_select = {ctrl[`TPC_CT_EDGE_HI], ctrl[`TPC_CT_EDGE_LO]};
  assign action_irq_enable = setup_ie[`TPC_SU_IE_ACT - 4];

  ////////////////////////////////////////////////////////////////////////////
  // APB slave: one wait state, side effects at the completing edge
  assign acc = psel & penable;
  assign wr_fire = acc & pwrite & pready;
  assign rd_fire = acc & ~pwrite & pready;

  // Read multiplexer and address decode
  always_comb begin
    read_mux = 32'h0000_0000;
    mapped = 1'b1;
    case (paddr)
      `TPC_OFS_SETUP: read_mux = {24'h000000, setup_ie, 1'b0, cap_level, 2'h0};
      `TPC_OFS_DIVISOR: read_mux = {20'h00000, divisor};
      `TPC_OFS_END: read_mux = {16'h0000, end_value};
      `TPC_OFS_COUNT: read_mux = {16'h0000, count};
      `TPC_OFS_STATUS: read_mux = {24'h000000, dma_done_flag, queue_overflow_flag,
                                   queue_request_flag, event_flag, queue_fill_level};
      `TPC_OFS_CONTROL: read_mux = {24'h000000, ctrl};
      `TPC_OFS_DMA_LEFT: read_mux = {24'h000000, dma_words_left};
      `TPC_OFS_DMA_LOW: read_mux = {24'h000000, dma_word_ptr[6:0], 1'b0};
      `TPC_OFS_DMA_HIGH: read_mux = {24'h000000, 4'h0, dma_word_ptr[10:7]};
      `TPC_OFS_QUEUE_LOW: read_mux = {24'h000000, head[7:0]};
      `TPC_OFS_QUEUE_HIGH: read_mux = {24'h000000, head[15:8]};
      default: mapped = 1'b0;
    endcase
  end

  // Registered answer; unmapped addresses answer with pslverr
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= acc & ~pready;
      pslverr <= acc & ~pready & ~mapped;
      prdata <= (acc & ~pready & ~pwrite) ? read_mux : 32'h0000_0000;
    end
  end

  // Software-written configuration
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      setup_ie <= 4'h0;
      ctrl <= `TPC_CONTROL_RESET;
      divisor <= `TPC_DIVISOR_RESET;
      end_value <= 16'h0000;
      queue_hold <= 8'h00;
    end else if (wr_fire) begin
      case (paddr)
        `TPC_OFS_SETUP: setup_ie <= pwdata[7:4];
        `TPC_OFS_DIVISOR: divisor <= pwdata[11:0];
        `TPC_OFS_END: end_value <= pwdata[15:0];
        `TPC_OFS_CONTROL: ctrl <= pwdata[7:0];
        `TPC_OFS_QUEUE_HIGH: queue_hold <= pwdata[7:0];
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Prescaler and counter
  assign div_m1 = (divisor == 12'h000) ? 12'h000 : divisor - 12'h001;
  assign tick = count_enable_bit & ~clear_all_bit & (prescale >= div_m1);
  assign end_m1 = end_value - 16'h0001;
  assign pwm_wrap = tick & ~capture_mode_select & ((end_value == 16'h0000) | (count >= end_m1));

  // Divider restarts whenever counting stops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prescale <= 12'h000;
    end else if (tick | ~count_enable_bit | clear_all_bit) begin
      prescale <= 12'h000;
    end else begin
      prescale <= prescale + 12'h001;
    end
  end

  // Shared count: PWM period in one mode, pulse width in the other
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count <= 16'h0000;
    end else if (clear_all_bit) begin
      count <= 16'h0000;
    end else if (capture_mode_select) begin
      if (cap_event) begin
        count <= 16'h0000;
      end else if (tick && (count != 16'hFFFF)) begin
        count <= count + 16'h0001;
      end
    end else if (pwm_wrap) begin
      count <= 16'h0000;
    end else if (tick) begin
      count <= count + 16'h0001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // PWM generator
  always_comb begin
    case (edge_select)
      `TPC_EDGE_OFF: rep_reload = `TPC_REP_1;
      `TPC_EDGE_ANY: rep_reload = `TPC_REP_4;
      `TPC_EDGE_FALL: rep_reload = `TPC_REP_8;
      default: rep_reload = `TPC_REP_16;
    endcase
  end

  // An empty queue keeps the last word running rather than dropping to 0%
  assign pwm_pop = pwm_wrap & (rep_left == 4'h0) & ~queue_empty & ~sw_pop;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pwm_word <= 16'h0000;
      rep_left <= 4'h0;
    end else if (clear_all_bit) begin
      pwm_word <= 16'h0000;
      rep_left <= 4'h0;
    end else if (pwm_wrap) begin
      if (rep_left != 4'h0) begin
        rep_left <= rep_left - 4'h1;
      end else if (pwm_pop) begin
        pwm_word <= head;
        rep_left <= rep_reload;
      end
    end
  end

  // Compare gives word/end duty; a word above end saturates at 100%
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pwm_out <= 1'b0;
      pwm_oe <= 1'b0;
    end else begin
      if (output_enable_bit && !capture_mode_select && (count < pwm_word)) begin
        pwm_out <= ~pwm_polarity;
      end else begin
        pwm_out <= pwm_polarity;
      end
      pwm_oe <= output_enable_bit & ~capture_mode_select;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Capture unit
  tpc_input_filter u_filter (
    .pclk(pclk),
    .presetn(presetn),
    .pin(capture_pin),
    .tick(tick),
    .min_one(pwm_polarity),
    .level(cap_level)
  );

  assign rise = cap_level & ~prev_level;
  assign fall = ~cap_level & prev_level;
  assign cap_en = capture_mode_select & count_enable_bit & ~clear_all_bit & (edge_select != `TPC_EDGE_OFF);
  always_comb begin
    case (edge_select)
      `TPC_EDGE_ANY: valid_edge = cap_en & (rise | fall);
      `TPC_EDGE_FALL: valid_edge = cap_en & fall;
      `TPC_EDGE_RISE: valid_edge = cap_en & rise;
      default: valid_edge = 1'b0;
    endcase
  end
  assign timeout = cap_en & tick & (count >= end_value) & ~valid_edge;
  assign cap_event = valid_edge | timeout;
  // Flag: measured level in any-edge mode, overflow mark otherwise
  assign cap_word = valid_edge ? {(edge_select == `TPC_EDGE_ANY) & prev_level, count[14:0]}
                               : {(edge_select != `TPC_EDGE_ANY) | cap_level, count[14:0]};
  assign cap_push = cap_event & ~first_word;

  // First word after enabling is not a full width and is dropped
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev_level <= 1'b1;
      first_word <= 1'b1;
    end else begin
      prev_level <= cap_level;
      if (!cap_en) begin
        first_word <= 1'b1;
      end else if (cap_event) begin
        first_word <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sample queue
  assign queue_empty = (queue_fill_level == 4'h0);
  assign queue_full = (queue_fill_level == `TPC_QUEUE_DEPTH);
  assign sw_push = wr_fire & (paddr == `TPC_OFS_QUEUE_LOW);
  assign sw_pop = rd_fire & (paddr == `TPC_OFS_QUEUE_LOW) & ~queue_empty;
  assign do_pop = sw_pop | pwm_pop | dma_pop;
  assign push_data = cap_push ? cap_word : (sw_push ? {queue_hold, pwdata[7:0]} : dma_buf);
  assign do_write = (cap_push | sw_push | dma_push) & ~clear_all_bit & (~queue_full | do_pop);
  assign overflow_evt = (cap_push | sw_push) & queue_full & ~do_pop & ~clear_all_bit;
  assign next_rd_ptr = clear_all_bit ? 3'h0 : rd_ptr + {2'h0, do_pop};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_ptr <= 3'h0;
      rd_ptr <= 3'h0;
      queue_fill_level <= 4'h0;
    end else if (clear_all_bit) begin
      wr_ptr <= 3'h0;
      rd_ptr <= 3'h0;
      queue_fill_level <= 4'h0;
    end else begin
      rd_ptr <= next_rd_ptr;
      if (do_write) begin
        wr_ptr <= wr_ptr + 3'h1;
      end
      case ({do_write, do_pop})
        2'b10: queue_fill_level <= queue_fill_level + 4'h1;
        2'b01: queue_fill_level <= queue_fill_level - 4'h1;
        default: ;
      endcase
    end
  end

  tpc_queue_mem u_mem (
    .pclk(pclk),
    .we(do_write),
    .waddr(wr_ptr),
    .wdata(push_data),
    .raddr(next_rd_ptr),
    .rdata(head)
  );

  ////////////////////////////////////////////////////////////////////////////
  // DMA channel: drains the queue in capture mode, fills it in PWM mode
  assign dma_run = dma_enable_bit & (dma_words_left != 8'h00);
  assign dma_pop = (dma_state == TPC_DMA_IDLE) & dma_run & capture_mode_select & ~queue_empty & ~sw_pop;
  assign dma_fetch = (dma_state == TPC_DMA_IDLE) & dma_run & ~capture_mode_select & ~queue_full;
  assign dma_push = (dma_state == TPC_DMA_HOLD) & ~cap_push & ~sw_push & ~queue_full;
  assign dma_finish = ((dma_state == TPC_DMA_BUSY) & dma_ack & dma_req.we) | dma_push;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dma_state <= TPC_DMA_IDLE;
      dma_req <= '0;
      dma_buf <= 16'h0000;
    end else begin
      case (dma_state)
        TPC_DMA_IDLE: begin
          if (dma_pop | dma_fetch) begin
            dma_req.req <= 1'b1;
            dma_req.we <= dma_pop;
            dma_req.addr <= {dma_word_ptr, 1'b0};
            dma_req.wdata <= head;
            dma_state <= TPC_DMA_BUSY;
          end
        end
        TPC_DMA_BUSY: begin
          if (dma_ack) begin
            dma_req.req <= 1'b0;
            dma_buf <= dma_rdata;
            dma_state <= dma_req.we ? TPC_DMA_IDLE : TPC_DMA_HOLD;
          end
        end
        TPC_DMA_HOLD: begin
          // Waits here while the queue is full or another source writes
          if (dma_push) begin
            dma_state <= TPC_DMA_IDLE;
          end
        end
        default: dma_state <= TPC_DMA_IDLE;
      endcase
    end
  end

  // Word count and pointer; a software preset beats the hardware step
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dma_words_left <= `TPC_DMA_LEFT_RESET;
    end else if (wr_fire && (paddr == `TPC_OFS_DMA_LEFT)) begin
      dma_words_left <= pwdata[7:0];
    end else if (dma_finish && (dma_words_left != 8'h00)) begin
      dma_words_left <= dma_words_left - 8'h01;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dma_word_ptr <= 11'h000;
    end else if (wr_fire && (paddr == `TPC_OFS_DMA_LOW)) begin
      dma_word_ptr[6:0] <= pwdata[7:1];
    end else if (wr_fire && (paddr == `TPC_OFS_DMA_HIGH)) begin
      dma_word_ptr[10:7] <= pwdata[3:0];
    end else if (dma_finish) begin
      dma_word_ptr <= dma_word_ptr + 11'h001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Status flags: a set in the same cycle as a clear wins
  assign stat_clr = (wr_fire && (paddr == `TPC_OFS_STATUS)) ? pwdata[7:0] : 8'h00;
  assign queue_access = (wr_fire | rd_fire) &
                        ((paddr == `TPC_OFS_QUEUE_LOW) | (paddr == `TPC_OFS_QUEUE_HIGH));
  assign act_evt = valid_edge | pwm_pop;
  assign end_evt = timeout | pwm_wrap;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dma_done_flag <= 1'b0;
    end else begin
      dma_done_flag <= (dma_finish & (dma_words_left == 8'h01)) |
                       (dma_done_flag & ~stat_clr[`TPC_ST_DMA_DONE] &
                        ~(wr_fire & (paddr == `TPC_OFS_DMA_LEFT)));
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      queue_overflow_flag <= 1'b0;
    end else begin
      queue_overflow_flag <= overflow_evt | (queue_overflow_flag & ~stat_clr[`TPC_ST_OVERFLOW]);
    end
  end

  // Request is level driven, so a clear only sticks once the level moves on
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      queue_request_flag <= 1'b0;
    end else begin
      queue_request_flag <= (capture_mode_select ? (queue_fill_level >= `TPC_REQ_CAPTURE)
                                                 : (queue_fill_level <= `TPC_REQ_PWM)) |
                            (queue_request_flag & ~stat_clr[`TPC_ST_REQUEST]);
    end
  end

  // Bit 4 has two meanings chosen by the action enable
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      event_flag <= 1'b0;
    end else if (action_irq_enable) begin
      event_flag <= act_evt | (event_flag & ~stat_clr[`TPC_ST_EVENT] & ~queue_access);
    end else begin
      event_flag <= end_evt | (event_flag & ~stat_clr[`TPC_ST_EVENT]);
    end
  end

  // Single request line from enabled flags
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
    end else begin
      irq <= (dma_done_flag & dma_enable_bit) |
             (queue_overflow_flag & setup_ie[`TPC_SU_IE_OV - 4]) |
             (queue_request_flag & setup_ie[`TPC_SU_IE_REQ - 4]) |
             (event_flag & (action_irq_enable | setup_ie[`TPC_SU_IE_END - 4]));
    end
  end
endmodule // tpc_timer_top
`default_nettype wire

// File: tpc_timer_monitor.sv
// Port checker for the timer block
`timescale 1ns/1ns
`default_nettype none
module tpc_timer_monitor
  import tpc_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire tpc_dma_req_type dma_req,
  input wire logic dma_ack
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Setup then first access cycle
  sequence s_access;
    psel && !penable ##1 psel && penable;
  endsequence
  // Request waiting for memory
  sequence s_dma_wait;
    dma_req.req && !dma_ack;
  endsequence
  a_ready_not_early: assert property (s_access |-> !pready) else $error("pready early");
  a_ready_second_cycle: assert property (s_access |=> pready) else $error("pready late");
  a_ready_one_cycle: assert property (pready |=> !pready) else $error("pready held");
  a_rdata_idle_zero: assert property (!pready |-> prdata == 32'h0) else $error("prdata not zero");
  a_slverr_with_ready: assert property (pslverr |-> pready) else $error("lone pslverr");
  a_slverr_on_unmapped: assert property (pready && paddr == 12'hFFC |-> pslverr) else $error("no pslverr");
  a_dma_req_hold: assert property (s_dma_wait |=> $stable(dma_req)) else $error("dma req moved");
  a_dma_req_drop: assert property (dma_req.req && dma_ack |=> !dma_req.req) else $error("req kept");
  a_dma_addr_even: assert property (dma_req.req |-> !dma_req.addr[0]) else $error("odd dma addr");
endmodule // tpc_timer_monitor
bind tpc_timer_top tpc_timer_monitor mon (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr), .dma_req(dma_req), .dma_ack(dma_ack));
`default_nettype wire

// File: tpc_mem_model.sv
// Data memory partner answering DMA requests
`timescale 1ns/1ns
`default_nettype none
module tpc_mem_model
  import tpc_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire tpc_dma_req_type dma_req,
  output logic dma_ack,
  output logic [15:0] dma_rdata
);
  int acks;
  int stall;
  // Random stall per word; data toggles outside the answer
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dma_ack <= 1'b0;
      dma_rdata <= 16'hFFFF;
      acks = 0;
      stall = 0;
    end else begin
      dma_ack <= 1'b0;
      dma_rdata <= ~dma_rdata;
      if (dma_req.req && !dma_ack && stall > 0) stall--;
      else if (dma_req.req && !dma_ack) begin
        dma_ack <= 1'b1;
        dma_rdata <= 16'h5A00 + 16'(acks);
        acks++;
        stall = $urandom_range(3);
      end
    end
  end
endmodule // tpc_mem_model
`default_nettype wire

// File: timer_pwm_capture_fifo_dma_bench.sv
// Self-checking bench for the timer block
`timescale 1ns/1ns
`default_nettype none
`include "tpc_regs.svh"
module timer_pwm_capture_fifo_dma_bench
  import tpc_pkg::*;
;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, capture_pin, pwm_out, dma_ack;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [15:0] dma_rdata;
  logic pwm_oe, irq;
  logic [31:0] high;
  logic [15:0] w[9];
  logic [63:0] note;
  logic [63:0] notes[$];
  tpc_dma_req_type dma_req;
  int errors, samples_checked;
  always #2 pclk = ~pclk;
  tpc_timer_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .capture_pin(capture_pin), .pwm_out(pwm_out), .pwm_oe(pwm_oe), .dma_req(dma_req), .dma_ack(dma_ack),
    .dma_rdata(dma_rdata), .irq(irq));
  tpc_mem_model mem (.pclk(pclk), .presetn(presetn), .dma_req(dma_req), .dma_ack(dma_ack),
    .dma_rdata(dma_rdata));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic summarize();
    $display("errors %0d samples_checked %0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // One APB transfer, held until pready
  task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk) penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  // Note the masked expectation, then read
  task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic [31:0] m);
    notes.push_back({m, e & m});
    xfer(1'b0, a, 32'h0);
  endtask
  // Read results compared against the oldest note
  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1 && !pwrite) begin
      note = notes.pop_front();
      check(prdata & note[63:32], note[31:0]);
    end
  end
  // Hang guard, far beyond the expected run
  initial begin
    #40000;
    errors++;
    summarize();
  end
  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    capture_pin = 1'b1;
    void'($urandom(32'h622A3D92));
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(`TPC_OFS_CONTROL, 32'h02, 32'hFF);
    // Empty queue in PWM mode raises the request flag straight after reset
    rd(`TPC_OFS_STATUS, 32'h20, 32'hFF);
    rd(`TPC_OFS_DMA_LEFT, 32'h00, 32'hFF);
    rd(12'hFFC, 32'h0, 32'hFFFFFFFF);
    xfer(1'b1, `TPC_OFS_DMA_LOW, 32'hFF);
    rd(`TPC_OFS_DMA_LOW, 32'hFE, 32'hFF);
    xfer(1'b1, `TPC_OFS_DMA_HIGH, 32'hFF);
    rd(`TPC_OFS_DMA_HIGH, 32'h0F, 32'hFF);
    // Nine pushes into eight places
    xfer(1'b1, `TPC_OFS_CONTROL, 32'h00);
    for (int i = 0; i < 9; i++) begin
      w[i] = 16'($urandom);
      xfer(1'b1, `TPC_OFS_QUEUE_HIGH, {24'h0, w[i][15:8]});
      xfer(1'b1, `TPC_OFS_QUEUE_LOW, {24'h0, w[i][7:0]});
    end
    rd(`TPC_OFS_STATUS, 32'h48, 32'hDF);
    check({31'h0, irq}, 32'h0);
    xfer(1'b1, `TPC_OFS_STATUS, 32'h40);
    rd(`TPC_OFS_STATUS, 32'h08, 32'hDF);
    for (int i = 0; i < 3; i++) begin
      rd(`TPC_OFS_QUEUE_HIGH, {24'h0, w[i][15:8]}, 32'hFF);
      rd(`TPC_OFS_QUEUE_LOW, {24'h0, w[i][7:0]}, 32'hFF);
    end
    xfer(1'b1, `TPC_OFS_CONTROL, 32'h02);
    rd(`TPC_OFS_STATUS, 32'h00, 32'h0F);
    xfer(1'b1, `TPC_OFS_CONTROL, 32'h22);
    repeat (2) @(posedge pclk);
    check({31'h0, pwm_out}, 32'h1);
    // Two PWM words fetched from memory
    xfer(1'b1, `TPC_OFS_DMA_LOW, 32'h10);
    xfer(1'b1, `TPC_OFS_DMA_HIGH, 32'h00);
    xfer(1'b1, `TPC_OFS_DMA_LEFT, 32'h02);
    xfer(1'b1, `TPC_OFS_CONTROL, 32'h10);
    while (mem.acks < 2) @(posedge pclk);
    repeat (4) @(posedge pclk);
    rd(`TPC_OFS_STATUS, 32'h82, 32'hDF);
    rd(`TPC_OFS_DMA_LEFT, 32'h00, 32'hFF);
    rd(`TPC_OFS_DMA_LOW, 32'h14, 32'hFF);
    for (int i = 0; i < 2; i++) begin
      rd(`TPC_OFS_QUEUE_HIGH, 32'h5A, 32'hFF);
      rd(`TPC_OFS_QUEUE_LOW, i, 32'hFF);
    end
    xfer(1'b1, `TPC_OFS_DMA_LEFT, 32'h00);
    rd(`TPC_OFS_STATUS, 32'h00, 32'h80);
    // PWM, one count per clock, period 4: word 2 is half duty, word 16 saturates
    xfer(1'b1, `TPC_OFS_DIVISOR, 32'h1);
    xfer(1'b1, `TPC_OFS_END, 32'h4);
    xfer(1'b1, `TPC_OFS_SETUP, 32'h80);
    xfer(1'b1, `TPC_OFS_QUEUE_HIGH, 32'h0);
    for (int k = 0; k < 2; k++) begin
      xfer(1'b1, `TPC_OFS_QUEUE_LOW, k ? 32'h10 : 32'h02);
      if (k == 0) xfer(1'b1, `TPC_OFS_CONTROL, 32'h0C);
      repeat (20) @(posedge pclk);
      // Whole periods only, so the window phase does not matter
      high = 32'h0;
      repeat (40) begin
        @(posedge pclk);
        high = high + {31'h0, pwm_out};
      end
      check(high, k ? 32'h28 : 32'h14);
    end
    check({30'h0, pwm_oe, irq}, 32'h3);
    // Rising-edge capture: first word dropped, falls ignored, idle pin times out
    xfer(1'b1, `TPC_OFS_CONTROL, 32'h02);
    xfer(1'b1, `TPC_OFS_END, 32'h100);
    xfer(1'b1, `TPC_OFS_CONTROL, 32'hE5);
    repeat (3) begin
      capture_pin <= 1'b0;
      repeat (8) @(posedge pclk);
      capture_pin <= 1'b1;
      repeat (8) @(posedge pclk);
    end
    // One timeout lands well before the second one could
    repeat (270) @(posedge pclk);
    rd(`TPC_OFS_STATUS, 32'h03, 32'h0F);
    for (int i = 0; i < 3; i++) begin
      rd(`TPC_OFS_QUEUE_HIGH, (i == 2) ? 32'h80 : 32'h0, 32'h80);
      rd(`TPC_OFS_QUEUE_LOW, 32'h0, 32'hE0);
    end
    @(posedge pclk);
    summarize();
  end
endmodule // timer_pwm_capture_fifo_dma_bench
`default_nettype wire
